// ==== common/sflc_pkg.sv ====
// Package for the serial flash controller: constants, enums and carrier structs.
// Assumes a single 100 MHz core clock and plain-port register access.
`default_nettype none
package sflc_pkg;
  // Core clock and link timing.
  localparam int CLK_MHZ = 100;
  localparam int SCK_MAX_MHZ = 20;
  // Half period of the serial clock in core cycles, rounded up to stay within the maximum rate.
  localparam int SCK_HALF_CYC = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  // Field positions and reset values.
  localparam int STRAP_VENDOR_BIT = 3;
  localparam logic [3:0] STRAP_RST = 4'h0;
  localparam logic [7:0] SIZE_CFG_RST = 8'h00;
  localparam int SIZE_FORCE_LO = 4;
  // Core cycles after reset release before the synchronised strap pins are valid.
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [1:0] FORCE_NONE = 2'h0;
  localparam logic [1:0] FORCE_BIT9 = 2'h1;
  localparam logic [1:0] FORCE_BIT10 = 2'h2;
  // Flash opcodes for the two vendor families.
  localparam logic [7:0] OP_RD_264 = 8'he8;
  localparam logic [7:0] OP_WR_264 = 8'h82;
  localparam logic [7:0] OP_ER_264 = 8'h81;
  localparam logic [7:0] OP_ID_264 = 8'hd7;
  localparam logic [7:0] OP_RD_256 = 8'h03;
  localparam logic [7:0] OP_WR_256 = 8'h0a;
  localparam logic [7:0] OP_ER_256 = 8'hdb;
  localparam logic [7:0] OP_ID_256 = 8'h9f;
  localparam int BYTE_MAX = 255;

  typedef enum logic [1:0] {CMD_WORD_WR, CMD_WORD_RD, CMD_STR_RD, CMD_ERASE} sflc_cmd_type;

  // One command as software issues it.
  typedef struct packed {
    sflc_cmd_type op;
    logic first;
    logic last;
    logic mode256;
  } sflc_req_type;

  // Bit-bang pin set: data out, data in, chip select low, clock.
  typedef struct packed {
    logic so;
    logic si;
    logic csN;
    logic sck;
  } sflc_pins_type;
endpackage : sflc_pkg
`default_nettype wire

// ==== hw/sflc_top.sv ====
// Serial flash controller: command sequencer, strap self-configuration, bit-bang,
// pass mode and a four-level access semaphore.
// Assumes flash pins are asynchronous to ref_clk; software drives the control ports.
//
// Notes on behaviour
// - Talks to flash over four SPI signals, clock at most 20 MHz.
// - Software acts only through command registers; controller runs the SPI transfer.
// - Sequencer supports word write, word read, string read and page erase.
// - Straps on SPI pins are sampled at reset to self-configure.
// - Top strap bit picks 264-byte family (1) or 256-byte family (0).
// - Sampled straps are readable in the strap reconfiguration register.
// - After reset the flash ID is read and size stored in size register.
// - Strap and size registers are writable to override auto configuration.
// - Page mode bit chooses 256-byte or legacy 264-byte pages.
// - In 256 mode page is addr[23:8], byte addr[7:0], bit 8 forced zero.
// - In 256 mode string reads roll to next page after a word starting at byte 0xFF.
// - In 256 mode size register bits 5:4 force address bit 9 or bit 10 to zero.
// - Legacy mode passes the 24-bit address straight to the flash.
// - Bit-bang enable makes low data register bits drive or show SPI pins.
// - Pass enable replaces command sequencing with pass mode.
// - Pass mode drives select per first/last and shifts out one software byte, then three more words for a string-read op.
// - Semaphore lets one of four requesters own the flash at a time.
// - Request level 0 has top priority, reserved for firmware.
`timescale 1ns/100ps
`default_nettype none
module sflc_top #(
  parameter int ADDR_W = 24
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cmdStart,
  input wire sflc_pkg::sflc_req_type cmdReq,
  input wire logic [31:0] writeDataReg,
  input wire logic [ADDR_W-1:0] flashAddressReg,
  output logic [31:0] readDataReg,
  output logic cmdDone,
  output logic cmdBusy,
  input wire logic bitbangEn,
  input wire logic passEn,
  input wire logic strapWrEn,
  input wire logic [3:0] strapWrData,
  output logic [3:0] strapReconfigReg,
  input wire logic sizeWrEn,
  input wire logic [7:0] sizeWrData,
  output logic [7:0] deviceSizeConfigReg,
  input wire logic [3:0] semReq,
  input wire logic [3:0] semRelease,
  output logic [3:0] semGrant,
  output logic spiSck,
  output logic spiCsN,
  output logic spiMosi,
  output logic spiMosiOe,
  input wire logic spiMiso,
  input wire logic spiMosiIn,
  input wire logic spiCsIn,
  input wire logic spiSckIn
);
  import sflc_pkg::*;

  typedef enum logic [2:0] {ST_STRAP, ST_IDLE, ST_SHIFT, ST_NEXT, ST_GAP} sflc_state_type;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pinMeta_q, pinSync_q;
  // The synchroniser resets low, so strap capture must wait until it has filled.
  // All pins that arrive from the flash side pass two flops before use.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta_q <= 4'h0;
      pinSync_q <= 4'h0;
    end else begin
      pinMeta_q <= {spiMiso, spiMosiIn, spiCsIn, spiSckIn};
      pinSync_q <= pinMeta_q;
    end
  end
  wire logic misoSync = pinSync_q[3];

  // ----------------------------------------------------------------
  // Semaphore
  // ----------------------------------------------------------------
  logic [3:0] grant_q, grant_d;
  // A release in the same cycle withdraws that level's request at once.
  // Adding one to the inverse isolates the lowest set bit, the highest priority.
  wire logic [3:0] pendReq = semReq & ~semRelease;
  wire logic [3:0] lowestReq = pendReq & (~pendReq + 4'h1);
  // A grant is held until its owner releases; only then may the lowest level win.
  always_comb begin
    grant_d = grant_q & ~semRelease;
    if (grant_d == 4'h0) begin
      grant_d = lowestReq;
    end
  end
  assign semGrant = grant_q;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [3:0] strap_q;
  logic [7:0] size_q;
  // Software writes take effect at once; the boot capture wins only in its own cycle.
  logic [1:0] strapCnt_q;
  logic idRun_q, wrap_q;
  wire logic vendor264 = strap_q[STRAP_VENDOR_BIT];
  assign strapReconfigReg = strap_q;
  assign deviceSizeConfigReg = size_q;

  // ----------------------------------------------------------------
  // Address mapping
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_q;
  sflc_req_type cmdReq_q;
  // The 256-byte mode clears bit 8 and the size-selected bit; legacy passes through.
  function automatic logic [ADDR_W-1:0] mapAddr(input logic [ADDR_W-1:0] a,
                                               input logic m256, input logic [1:0] frc);
    logic [ADDR_W-1:0] r;
    r = a;
    if (m256) begin
      r[8] = 1'b0;
      if (frc == FORCE_BIT9) r[9] = 1'b0;
      if (frc == FORCE_BIT10) r[10] = 1'b0;
    end
    return r;
  endfunction
  wire logic [1:0] forceSel = size_q[SIZE_FORCE_LO +: 2];
  wire logic [ADDR_W-1:0] physAddr = mapAddr(addr_q, cmdReq_q.mode256, forceSel);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sflc_state_type state_q;
  logic [63:0] shift_q;
  logic [6:0] bitsLeft_q;
  logic [1:0] words_q;
  logic [31:0] rdata_q;
  logic done_q, sck_q, csN_q;
  logic [$clog2(SCK_HALF_CYC+1)-1:0] div_q;
  wire logic tick = (div_q == '0);

  // Opcode lookup by family and command.
  function automatic logic [7:0] opcode(input logic v264, input sflc_cmd_type c);
    unique case (c)
      CMD_WORD_WR: return v264 ? OP_WR_264 : OP_WR_256;
      CMD_ERASE: return v264 ? OP_ER_264 : OP_ER_256;
      default: return v264 ? OP_RD_264 : OP_RD_256;
    endcase
  endfunction

  // A page roll is only needed on reads; writes must end their page with last.
  // The check uses the word's start address, so a string read must be placed to suit.
  wire logic isRead = (cmdReq_q.op == CMD_WORD_RD) || (cmdReq_q.op == CMD_STR_RD);
  wire logic pageWrap = cmdReq_q.mode256 && isRead && (addr_q[7:0] == 8'(BYTE_MAX));
  wire logic autoStart = cmdStart && (cmdBusy == 1'b0) && !bitbangEn;
  wire logic sfMode = !bitbangEn;

  // Serial clock divider: a tick every SCK_HALF_CYC cycles keeps SCK within 20 MHz.
  // It runs freely, so only the select-to-clock setup may be short, never a clock phase.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) div_q <= '0;
    else div_q <= tick ? ($bits(div_q))'(SCK_HALF_CYC - 1) : div_q - 1'b1;
  end

  // Main sequencer: strap capture, ID read, commands, pass mode and page rollover.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_STRAP;
      strap_q <= STRAP_RST;
      size_q <= SIZE_CFG_RST;
      strapCnt_q <= 2'h0;
      idRun_q <= 1'b0;
      wrap_q <= 1'b0;
      cmdReq_q <= '0;
      addr_q <= '0;
      shift_q <= '0;
      bitsLeft_q <= '0;
      words_q <= '0;
      rdata_q <= '0;
      done_q <= 1'b0;
      sck_q <= 1'b0;
      csN_q <= 1'b1;
      grant_q <= 4'h0;
    end else begin
      grant_q <= grant_d;
      if (strapWrEn) strap_q <= strapWrData;
      if (sizeWrEn) size_q <= sizeWrData;
      unique case (state_q)
        ST_STRAP: begin
          // Straps are caught once the two-flop synchroniser holds the pin levels.
          // Reading earlier would capture the synchroniser's reset value instead.
          if (strapCnt_q != STRAP_SETTLE) begin
            strapCnt_q <= strapCnt_q + 2'h1;
          end else begin
            strap_q <= pinSync_q;
            idRun_q <= 1'b1;
            cmdReq_q <= '{op: CMD_WORD_RD, first: 1'b1, last: 1'b1, mode256: 1'b0};
            shift_q <= {(pinSync_q[STRAP_VENDOR_BIT] ? OP_ID_264 : OP_ID_256), 56'h0};
            bitsLeft_q <= 7'd16;
            words_q <= 2'd0;
            csN_q <= 1'b0;
            state_q <= ST_SHIFT;
          end
        end
        ST_IDLE: begin
          // Starts while busy or in bit-bang are dropped without any trace.
          // Pass mode reuses the shifter and sends the software byte, followed by three more words for a string-read op.
          if (autoStart) begin
            done_q <= 1'b0;
            cmdReq_q <= cmdReq;
            addr_q <= flashAddressReg;
            if (cmdReq.first) csN_q <= 1'b0;
            if (passEn) begin
              shift_q <= {writeDataReg[7:0], 56'h0};
              bitsLeft_q <= 7'd8;
            end else begin
              shift_q <= {opcode(vendor264, cmdReq.op),
                          mapAddr(flashAddressReg, cmdReq.mode256, forceSel),
                          writeDataReg};
              bitsLeft_q <= (cmdReq.op == CMD_ERASE) ? 7'd32 : 7'd64;
            end
            words_q <= (cmdReq.op == CMD_STR_RD) ? 2'd3 : 2'd0;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          // The serial clock only runs here, so it stands still between frames.
          if (tick) begin
            sck_q <= ~sck_q;
            if (sck_q) begin
              // Falling edge moves the next bit out and keeps the sampled one.
              shift_q <= {shift_q[62:0], misoSync};
              bitsLeft_q <= bitsLeft_q - 7'd1;
              if (bitsLeft_q == 7'd1) state_q <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          // One word is complete: keep it, step the address and pick the next step.
          rdata_q <= shift_q[31:0];
          addr_q <= addr_q + ADDR_W'(4);
          idRun_q <= 1'b0;
          // Only the boot-time ID read loads the size, and only if nobody overrode it.
          if (idRun_q && size_q == SIZE_CFG_RST) begin
            size_q <= shift_q[7:0];
          end
          wrap_q <= pageWrap && (words_q != 2'd0);
          if (words_q != 2'd0) begin
            words_q <= words_q - 2'd1;
            bitsLeft_q <= 7'd32;
            if (pageWrap) begin
              // Deselect closes the page; the gap state reopens at the next address.
              csN_q <= 1'b1;
              state_q <= ST_GAP;
            end else begin
              state_q <= ST_SHIFT;
            end
          end else begin
            // Without last the select stays low, so pass-mode bytes can be chained.
            if (cmdReq_q.last) csN_q <= 1'b1;
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          // A wrapped string read reopens the next page with a fresh opcode and address.
          if (wrap_q) begin
            wrap_q <= 1'b0;
            csN_q <= 1'b0;
            shift_q <= {opcode(vendor264, cmdReq_q.op), physAddr, 32'h0};
            bitsLeft_q <= 7'd64;
            state_q <= ST_SHIFT;
          end else begin
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin and status outputs
  // ----------------------------------------------------------------
  // In bit-bang mode the low register bits are the pins; software owns timing.
  wire sflc_pins_type bbPins = sflc_pins_type'(writeDataReg[3:0]);
  assign spiSck = sfMode ? sck_q : bbPins.sck;
  assign spiCsN = sfMode ? csN_q : bbPins.csN;
  assign spiMosi = sfMode ? shift_q[63] : bbPins.si;
  // The data-out line is always driven; strap levels arrive on separate inputs.
  assign spiMosiOe = 1'b1;
  assign readDataReg = bitbangEn ? {28'h0, pinSync_q} : rdata_q;
  assign cmdDone = done_q;
  assign cmdBusy = (state_q != ST_IDLE);
endmodule // sflc_top
`default_nettype wire

// ==== bench/sflc_checker.sv ====
// Assertion checker for the serial flash controller top level.
// Bound into sflc_top; sees only its ports, all in the ref_clk domain.
`timescale 1ns/100ps
`default_nettype none
module sflc_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cmdStart,
  input wire sflc_pkg::sflc_req_type cmdReq,
  input wire logic [31:0] writeDataReg,
  input wire logic cmdDone,
  input wire logic cmdBusy,
  input wire logic bitbangEn,
  input wire logic strapWrEn,
  input wire logic [3:0] strapWrData,
  input wire logic [3:0] strapReconfigReg,
  input wire logic [3:0] semReq,
  input wire logic [3:0] semRelease,
  input wire logic [3:0] semGrant,
  input wire logic spiSck,
  input wire logic spiCsN,
  input wire logic spiMosi
);
  import sflc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // Command, link, strap override and semaphore properties
  // ---------------------------------------------------------------
  // A start counts only when idle and not bit-banging.
  sequence s_take;
    cmdStart && !cmdBusy && !bitbangEn;
  endsequence
  // Bit-bang pins are judged only after the request has settled.
  sequence s_bb_still;
    (bitbangEn && $stable(writeDataReg))[*3];
  endsequence
  a_sck_high_min:
    assert property ($rose(spiSck) |-> spiSck[*3]) else $error("serial clock high too short");
  a_sck_low_min:
    assert property ($fell(spiSck) |-> (!spiSck)[*3]) else $error("serial clock low too short");
  a_take_clears_done:
    assert property (s_take |=> cmdBusy && !cmdDone) else $error("start did not clear done");
  a_done_not_busy:
    assert property (cmdDone |-> !cmdBusy) else $error("done while busy");
  a_first_selects:
    assert property (s_take ##0 cmdReq.first |-> ##[1:4] !spiCsN) else $error("select missing");
  a_grant_one_hot:
    assert property ($onehot0(semGrant)) else $error("more than one grant");
  a_grant_held:
    assert property (semGrant != 4'h0 && (semGrant & semRelease) == 4'h0 |=>
      semGrant == $past(semGrant)) else $error("grant lost without release");
  a_grant_lowest:
    assert property (semGrant == 4'h0 && semReq != 4'h0 |=>
      semGrant == ($past(semReq) & (~$past(semReq) + 4'h1))) else $error("wrong grant");
  a_strap_override:
    assert property (strapWrEn |=> strapReconfigReg == $past(strapWrData))
      else $error("strap write lost");
  a_bb_pins_follow:
    assert property (s_bb_still |-> {spiMosi, spiCsN, spiSck} == writeDataReg[2:0])
      else $error("bit-bang pins wrong");
endmodule // sflc_checker
bind sflc_top sflc_checker chk (.ref_clk, .sys_rst, .cmdStart, .cmdReq, .writeDataReg,
  .cmdDone, .cmdBusy, .bitbangEn, .strapWrEn, .strapWrData, .strapReconfigReg, .semReq,
  .semRelease, .semGrant, .spiSck, .spiCsN, .spiMosi);
`default_nettype wire

// ==== bench/sflc_flash_model.sv ====
// Behavioural serial flash: mode 0 framing, answers ID and word reads.
// Assumes the controller is the only master on the four SPI signals.
`timescale 1ns/100ps
`default_nettype none
module sflc_flash_model #(
  parameter logic [15:0] ID_WORD = 16'h3c05, // Arbitrary value.
  parameter logic PULL_LVL = 1'b1
) (
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic [31:0] rdWord,
  output logic miso,
  output logic [7:0] lastOp,
  output logic [23:0] lastAddr
);
  import sflc_pkg::*;
  logic [31:0] rx = 32'h0;
  logic [63:0] tx = 64'h0;
  int cnt = 0;
  // ---------------------------------------------------------------
  // Framing and shifting
  // ---------------------------------------------------------------
  // A falling select starts a new frame.
  always @(negedge csN) cnt = 0;
  // Data in is taken on the rising clock; the answer is queued after the opcode.
  always @(posedge sck) if (!csN) begin
    rx = {rx[30:0], mosi};
    cnt++;
    if (cnt == 8) begin
      lastOp = rx[7:0];
      tx = (rx[7:0] == OP_ID_264 || rx[7:0] == OP_ID_256) ? {1'b0, ID_WORD, 47'h0}
        : {25'h0, rdWord, 7'h0};
    end
    if (cnt == 32) lastAddr = rx[23:0];
  end
  // Filler toggles so a stale bit is never mistaken for data.
  always @(negedge sck) tx = {tx[62:0], ~tx[0]};
  // Deselected, the pull-up sets the level, not the last bit.
  assign miso = csN ? PULL_LVL : tx[63];
endmodule // sflc_flash_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the serial flash controller with a flash model.
// Assumes the checker binds itself into the controller.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sflc_pkg::*;
  localparam logic [3:0] STRAP = 4'hb;
  localparam logic [15:0] ID_WORD = 16'h3c05; // Arbitrary value.
  logic ref_clk = 1'b0, sys_rst = 1'b1, cmdStart = 1'b0, strapHold = 1'b1;
  logic bitbangEn = 1'b0, passEn = 1'b0, strapWrEn = 1'b0, sizeWrEn = 1'b0;
  logic cmdDone, cmdBusy, spiSck, spiCsN, spiMosi, spiMiso, spiMosiOe;
  sflc_req_type cmdReq = '0;
  logic [31:0] writeDataReg = 32'h0, rdWord = 32'h0, readDataReg, r;
  logic [23:0] flashAddressReg = 24'h0, lastAddr;
  logic [3:0] strapWrData = 4'h0, semReq = 4'h0, semRelease = 4'h0, strapReconfigReg, semGrant;
  logic [7:0] sizeWrData = 8'h0, deviceSizeConfigReg, lastOp;
  int error_cnt = 0, checks = 0, seed = 10079, cyc = 0;
  // ---------------------------------------------------------------
  // Design, far side and clock
  // ---------------------------------------------------------------
  // Pins show the straps until the controller drives them.
  sflc_top dut (.ref_clk, .sys_rst, .cmdStart, .cmdReq, .writeDataReg, .flashAddressReg,
    .readDataReg, .cmdDone, .cmdBusy, .bitbangEn, .passEn, .strapWrEn, .strapWrData,
    .strapReconfigReg, .sizeWrEn, .sizeWrData, .deviceSizeConfigReg, .semReq, .semRelease,
    .semGrant, .spiSck, .spiCsN, .spiMosi, .spiMosiOe, .spiMiso,
    .spiMosiIn(strapHold ? STRAP[2] : spiMosi), .spiCsIn(strapHold ? STRAP[1] : spiCsN),
    .spiSckIn(strapHold ? STRAP[0] : spiSck));
  sflc_flash_model #(.ID_WORD(ID_WORD)) flash (.sck(spiSck), .csN(spiCsN), .mosi(spiMosi),
    .rdWord, .miso(spiMiso), .lastOp, .lastAddr);
  always #5 ref_clk = ~ref_clk;
  // A hang counts as a mismatch and closes the run.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (cmdBusy !== 1'b0 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    cmp("busy", 32'h0, {31'h0, cmdBusy});
  endtask
  task automatic do_cmd(input sflc_cmd_type op, input logic m256, input logic [23:0] a);
    @(negedge ref_clk);
    cmdReq = '{op: op, first: 1'b1, last: 1'b1, mode256: m256};
    flashAddressReg = a;
    cmdStart = 1'b1;
    @(negedge ref_clk);
    cmdStart = 1'b0;
    wait_idle();
    cmp("done", 32'h1, {31'h0, cmdDone});
  endtask
  task automatic wr_cfg(input logic [3:0] s, input logic [7:0] z);
    @(negedge ref_clk);
    {strapWrEn, strapWrData, sizeWrEn, sizeWrData} = {1'b1, s, 1'b1, z};
    @(negedge ref_clk);
    {strapWrEn, sizeWrEn} = 2'b00;
    cmp("strap", {28'h0, s}, {28'h0, strapReconfigReg});
    cmp("size", {24'h0, z}, {24'h0, deviceSizeConfigReg});
  endtask
  function automatic logic [7:0] exp_op(input logic [1:0] op, input logic f264);
    case (op)
      2'h0: return f264 ? OP_WR_264 : OP_WR_256;
      2'h3: return f264 ? OP_ER_264 : OP_ER_256;
      default: return f264 ? OP_RD_264 : OP_RD_256;
    endcase
  endfunction
  function automatic logic [23:0] exp_adr(input logic [23:0] a, input logic m, input logic [1:0] f);
    if (!m) return a;
    a[8] = 1'b0;
    if (f == FORCE_BIT9) a[9] = 1'b0;
    if (f == FORCE_BIT10) a[10] = 1'b0;
    return a;
  endfunction
  // Last address sent: a 256-mode string read whose word starts at byte 0xFF reopens.
  function automatic logic [23:0] exp_end(input logic [23:0] a, input logic [1:0] op,
      input logic m, input logic [1:0] f);
    logic [23:0] hit;
    hit = a;
    if (op == 2'h2 && m) begin
      for (int k = 0; k < 3; k++) begin
        if (a[7:0] + 8'(4 * k) == 8'hff) hit = a + 24'(4 * k + 4);
      end
    end
    return exp_adr(hit, m, f);
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence; every wait is bounded so one hang cannot mask the rest.
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    strapHold = 1'b0;
    wait_idle();
    cmp("strap", {28'h0, STRAP}, {28'h0, strapReconfigReg});
    cmp("size", {24'h0, ID_WORD[15:8]}, {24'h0, deviceSizeConfigReg});
    cmp("data out enable", 32'h1, {31'h0, spiMosiOe});
    $display("test self_config done");
    for (int i = 0; i < 8; i++) begin
      wr_cfg(STRAP, {2'h0, 2'(i % 3), 4'h5});
      r = $random(seed);
      rdWord = $random(seed);
      if (i == 0) r[7:0] = 8'hff;
      if (i == 2) {r[31], r[7:0]} = {1'b1, 8'hff};
      do_cmd(sflc_cmd_type'(i % 4), r[31], r[23:0]);
      cmp("opcode", {24'h0, exp_op(2'(i % 4), 1'b1)}, {24'h0, lastOp});
      cmp("addr", 32'(exp_end(r[23:0], 2'(i % 4), r[31], 2'(i % 3))),
        32'(lastAddr));
      if (i % 4 == 1) cmp("read", rdWord, readDataReg);
    end
    wr_cfg(4'h3, 8'h05);
    do_cmd(CMD_WORD_RD, 1'b0, 24'h000123);
    cmp("opcode", {24'h0, OP_RD_256}, {24'h0, lastOp});
    $display("test commands done");
    semReq = 4'b1010;
    repeat (3) @(negedge ref_clk);
    cmp("grant", 32'h2, {28'h0, semGrant});
    semReq = 4'b1011;
    repeat (3) @(negedge ref_clk);
    cmp("grant", 32'h2, {28'h0, semGrant});
    {semReq, semRelease} = {4'b1001, 4'b0010};
    @(negedge ref_clk);
    semRelease = 4'h0;
    repeat (3) @(negedge ref_clk);
    cmp("grant", 32'h1, {28'h0, semGrant});
    $display("test semaphore done");
    bitbangEn = 1'b1;
    repeat (4) begin
      r = $random(seed);
      writeDataReg = {28'h0, r[3:2], 1'b1, r[0]};
      repeat (6) @(negedge ref_clk);
      cmp("pins", {28'h0, PULL_HI(), r[2], 1'b1, r[0]}, readDataReg);
    end
    bitbangEn = 1'b0;
    passEn = 1'b1;
    writeDataReg = {24'h0, r[15:8]};
    do_cmd(CMD_WORD_WR, 1'b0, 24'h0);
    cmp("pass byte", {24'h0, r[15:8]}, {24'h0, lastOp});
    cmp("select", 32'h1, {31'h0, spiCsN});
    passEn = 1'b0;
    $display("test bitbang_pass done");
    report_and_stop();
  end
  function automatic logic PULL_HI();
    return 1'b1;
  endfunction
endmodule // tb_top
`default_nettype wire
